// >>> inc/otr_pkg.sv
// Purpose: Shared constants and types for the over-temperature fault response block
// Assumes: Temperatures and limits use the 16-bit linear number format
// Notes:   Decoded values are signed fixed point with FIX_FRAC fraction bits
package otr_pkg;
  // Command codes of the held registers
  localparam logic [7:0]  CMD_OT_FLT_LIM = 8'h4f;
  localparam logic [7:0]  CMD_OT_REACT   = 8'h50;
  localparam logic [7:0]  CMD_OT_WARN    = 8'h51;
  localparam logic [7:0]  CMD_UT_WARN    = 8'h52;
  // Values after reset: latch-off reaction, 125, 105 and -40 degrees
  localparam logic [7:0]  REACT_RST      = 8'hc0;
  localparam logic [15:0] OT_FLT_RST     = 16'h007d;
  localparam logic [15:0] OT_WARN_RST    = 16'h0069;
  localparam logic [15:0] UT_WARN_RST    = 16'h07d8;
  // Reaction byte field positions
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB   = 2;
  localparam logic [2:0]  RETRY_NONE    = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;
  // Decoded fixed-point width and linear exponent bias
  localparam int FIX_W    = 48;
  localparam int FIX_FRAC = 16;
  localparam int MANT_W   = 11;
  localparam int CNT_W    = 23;
  localparam logic [4:0]  EXP_BIAS_FLIP = 5'h10;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_DEFER  = 2'h1,
    RESP_RETRY  = 2'h2,
    RESP_LATCH  = 2'h3
  } otr_resp_t;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_DEFER = 4'h2,
    ST_RETRY = 4'h4,
    ST_LATCH = 4'h8
  } otr_state_t;
endpackage : otr_pkg

// >>> inc/otr_tmr_if.sv
// Purpose: Carrier between the response controller and its delay timer
// Assumes: One clock domain
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ps
interface otr_tmr_if;
  logic       start;
  logic [2:0] code;
  logic       busy;
  logic       done;
  modport ctl (output start, output code, input busy, input done);
  modport tmr (input start, input code, output busy, output done);
endinterface : otr_tmr_if

// >>> rtl/otr_delay_timer.sv
// Purpose: Counts the decoded delay, unit length times two to the code
// Assumes: unit_in is the delay unit in clock cycles; zero is taken as one
// Notes:   A start while busy restarts the count
`timescale 1ns/1ps
module otr_delay_timer
  import otr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] unit_in,
  otr_tmr_if.tmr           tmr
);
  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;
  logic             done_r;
  logic [CNT_W-1:0] total;

  assign total = {7'h00, (unit_in == 16'h0000) ? 16'h0001 : unit_in} << tmr.code;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (tmr.start)
    begin
      cnt_r  <= total - 23'h000001;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end
    else if (busy_r && cnt_r == '0)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= busy_r ? cnt_r - 23'h000001 : cnt_r;
      done_r <= 1'b0;
    end
  end

  assign tmr.busy = busy_r;
  assign tmr.done = done_r;

  delay_len_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (tmr.start && unit_in == 16'h0002 && tmr.code == 3'h1) ##1 (!tmr.start) [*4]
    |=> tmr.done)
    else $error("delay of code 1 did not end after four cycles");
endmodule : otr_delay_timer

// >>> rtl/otr_fault_resp.sv
// Purpose: Over-temperature fault reaction, retry sequencing and limit registers
// Assumes: Inputs synchronous to ref_clk_in; delay unit length comes from outside
// Notes:   Output is on only while both the pin and the operation command ask for it
`timescale 1ns/1ps

module otr_fault_resp
  import otr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  output logic             cmd_ack_out,
  output logic             cmd_nak_out,
  output logic [15:0]      cmd_rdata_out,
  input  wire logic        clear_faults_in,
  input  wire logic        ot_flag_clr_in,
  input  wire logic        ctrl_pin_on_in,
  input  wire logic        operation_on_in,
  input  wire logic        other_fault_in,
  input  wire logic [15:0] temp_in,
  input  wire logic [15:0] delay_unit_in,
  output logic             power_en_out,
  output logic             retry_attempt_out,
  output logic             ot_fault_flag_out,
  output logic             ot_warn_flag_out,
  output logic             ut_warn_flag_out
);
  logic [7:0]  react_r;
  logic [15:0] ot_flt_r;
  logic [15:0] ot_warn_r;
  logic [15:0] ut_warn_r;
  logic        ack_r;
  logic        nak_r;
  logic [15:0] rdata_r;
  logic        hit;
  logic        wr_en;

  otr_state_t  state_r;
  otr_state_t  state_nxt;
  logic [2:0]  retry_left_r;
  logic        power_en_r;
  logic        attempt_r;
  logic        ot_flag_r;
  logic        otw_flag_r;
  logic        utw_flag_r;

  otr_resp_t   resp;
  logic [2:0]  retries;
  logic        cmd_on;
  logic        ot_fault;
  logic        ot_warn_hit;
  logic        ut_warn_hit;
  logic        fault_clr;
  logic        off_go;
  logic        load_retry;
  logic        dec_retry;
  logic        attempt;
  logic        tmr_start;

  logic [15:0]             lin_src [4];
  logic signed [FIX_W-1:0] fix_val [4];

  otr_tmr_if tmr_if ();

  otr_delay_timer u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .unit_in    (delay_unit_in),
    .tmr        (tmr_if.tmr)
  );

  assign tmr_if.start = tmr_start;
  assign tmr_if.code  = react_r[DLY_MSB:0];

  assign lin_src[0] = temp_in;
  assign lin_src[1] = ot_flt_r;
  assign lin_src[2] = ot_warn_r;
  assign lin_src[3] = ut_warn_r;

  for (genvar g = 0; g < 4; g++)
  begin : g_dec
    otr_lin_decode u_dec (
      .lin_in  (lin_src[g]),
      .fix_out (fix_val[g])
    );
  end

  assign ot_fault    = fix_val[0] > fix_val[1];
  assign ot_warn_hit = fix_val[0] > fix_val[2];
  assign ut_warn_hit = fix_val[0] < fix_val[3];

  assign resp      = otr_resp_t'(react_r[RESP_MSB:RESP_LSB]);
  assign retries   = react_r[RETRY_MSB:RETRY_LSB];
  assign cmd_on    = ctrl_pin_on_in & operation_on_in;
  assign fault_clr = clear_faults_in | ot_flag_clr_in;

  // Command port: every code answers the cycle after, unknown codes with a nak
  assign hit   = cmd_code_in inside {CMD_OT_FLT_LIM, CMD_OT_REACT, CMD_OT_WARN, CMD_UT_WARN};
  assign wr_en = cmd_valid_in & cmd_write_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_r   <= 1'b0;
      nak_r   <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r <= cmd_valid_in & hit;
      nak_r <= cmd_valid_in & ~hit;
      if (cmd_valid_in && !cmd_write_in)
      begin
        unique case (cmd_code_in)
          CMD_OT_FLT_LIM: rdata_r <= ot_flt_r;
          CMD_OT_REACT:   rdata_r <= {8'h00, react_r};
          CMD_OT_WARN:    rdata_r <= ot_warn_r;
          CMD_UT_WARN:    rdata_r <= ut_warn_r;
          default:        rdata_r <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      react_r <= REACT_RST;
    end
    else if (wr_en && cmd_code_in == CMD_OT_REACT)
    begin
      react_r <= cmd_wdata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ot_flt_r <= OT_FLT_RST;
    end
    else if (wr_en && cmd_code_in == CMD_OT_FLT_LIM)
    begin
      ot_flt_r <= cmd_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ot_warn_r <= OT_WARN_RST;
      ut_warn_r <= UT_WARN_RST;
    end
    else if (wr_en)
    begin
      if (cmd_code_in == CMD_OT_WARN)
      begin
        ot_warn_r <= cmd_wdata_in;
      end
      if (cmd_code_in == CMD_UT_WARN)
      begin
        ut_warn_r <= cmd_wdata_in;
      end
    end
  end

  // Reaction sequencer; commanding off overrides everything
  always_comb
  begin
    state_nxt  = state_r;
    off_go     = 1'b0;
    load_retry = 1'b0;
    dec_retry  = 1'b0;
    attempt    = 1'b0;
    tmr_start  = 1'b0;
    if (!cmd_on)
    begin
      state_nxt = ST_RUN;
    end
    else
    begin
      unique case (state_r)
        ST_RUN:
          if (ot_fault)
          begin
            unique case (resp)
              RESP_IGNORE: state_nxt = ST_RUN;
              RESP_DEFER:
              begin
                state_nxt = ST_DEFER;
                tmr_start = 1'b1;
              end
              RESP_RETRY: off_go = 1'b1;
              RESP_LATCH: state_nxt = ST_LATCH;
            endcase
          end
        ST_DEFER:
          if (tmr_if.done)
          begin
            if (ot_fault)
            begin
              off_go = 1'b1;
            end
            else
            begin
              state_nxt = ST_RUN;
            end
          end
        ST_RETRY:
          if (other_fault_in)
          begin
            state_nxt = ST_LATCH;
          end
          else if (tmr_if.done)
          begin
            attempt   = 1'b1;
            dec_retry = 1'b1;
            if (!ot_fault)
            begin
              state_nxt = ST_RUN;
            end
            else if (retries != RETRY_FOREVER && retry_left_r <= 3'h1)
            begin
              state_nxt = ST_LATCH;
            end
            else
            begin
              tmr_start = 1'b1;
            end
          end
        ST_LATCH:
          if (fault_clr)
          begin
            state_nxt = ST_RUN;
          end
        default: state_nxt = ST_RUN;
      endcase
      if (off_go)
      begin
        if (retries == RETRY_NONE)
        begin
          state_nxt = ST_LATCH;
        end
        else
        begin
          state_nxt  = ST_RETRY;
          tmr_start  = 1'b1;
          load_retry = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      retry_left_r <= '0;
    end
    else if (load_retry)
    begin
      retry_left_r <= retries;
    end
    else if (dec_retry && retries != RETRY_FOREVER && retry_left_r != '0)
    begin
      retry_left_r <= retry_left_r - 3'h1;
    end
  end

  // Output registered from the next state so it drops with the state change
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      power_en_r <= 1'b0;
      attempt_r  <= 1'b0;
    end
    else
    begin
      power_en_r <= cmd_on & (state_nxt == ST_RUN || state_nxt == ST_DEFER);
      attempt_r  <= attempt;
    end
  end

  // Sticky flags; a new hit in the clearing cycle wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ot_flag_r  <= 1'b0;
      otw_flag_r <= 1'b0;
      utw_flag_r <= 1'b0;
    end
    else
    begin
      ot_flag_r  <= ot_fault | (ot_flag_r & ~fault_clr);
      otw_flag_r <= ot_warn_hit | (otw_flag_r & ~clear_faults_in);
      utw_flag_r <= ut_warn_hit | (utw_flag_r & ~clear_faults_in);
    end
  end

  assign cmd_ack_out       = ack_r;
  assign cmd_nak_out       = nak_r;
  assign cmd_rdata_out     = rdata_r;
  assign power_en_out      = power_en_r;
  assign retry_attempt_out = attempt_r;
  assign ot_fault_flag_out = ot_flag_r;
  assign ot_warn_flag_out  = otw_flag_r;
  assign ut_warn_flag_out  = utw_flag_r;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_run_fault;
    state_r == ST_RUN && ot_fault && cmd_on;
  endsequence

  sequence s_retry_fail;
    state_r == ST_RETRY && tmr_if.done && ot_fault && cmd_on && !other_fault_in;
  endsequence

  ignore_keep_on_a: assert property (s_run_fault ##0 resp == RESP_IGNORE
    |=> power_en_out && state_r == ST_RUN)
    else $error("ignore reaction disturbed the output");

  defer_run_on_a: assert property (s_run_fault ##0 resp == RESP_DEFER
    |=> power_en_out && tmr_if.busy)
    else $error("run-on delay not started with output on");

  defer_expire_a: assert property (state_r == ST_DEFER && tmr_if.done && ot_fault
    && cmd_on |=> !power_en_out)
    else $error("output stayed on after run-on delay with fault");

  disable_now_a: assert property (s_run_fault ##0 resp == RESP_RETRY
    |=> !power_en_out)
    else $error("disable reaction did not drop the output");

  latch_hold_a: assert property (state_r == ST_LATCH && cmd_on && !fault_clr
    |=> state_r == ST_LATCH && !power_en_out)
    else $error("latched fault released without a clear");

  off_on_clear_a: assert property (!cmd_on ##1 cmd_on
    |-> state_r == ST_RUN)
    else $error("off and on cycle did not clear the fault");

  no_retry_a: assert property (off_go && retries == RETRY_NONE
    |=> state_r == ST_LATCH)
    else $error("restart attempted with retry setting zero");

  retry_load_a: assert property (load_retry
    |=> retry_left_r == $past(retries) && state_r == ST_RETRY)
    else $error("attempt budget not loaded from retry setting");

  retry_out_a: assert property (s_retry_fail ##0 retries != RETRY_FOREVER
    && retry_left_r == 3'h1 |=> state_r == ST_LATCH ##1 !power_en_out)
    else $error("last failed attempt did not latch off");

  forever_retry_a: assert property (s_retry_fail ##0 retries == RETRY_FOREVER
    |=> state_r == ST_RETRY && tmr_if.busy)
    else $error("endless retry stopped early");

  other_stop_a: assert property (state_r == ST_RETRY && other_fault_in && cmd_on
    |=> state_r == ST_LATCH)
    else $error("other fault did not stop retrying");

  warn_flag_a: assert property ((ot_warn_hit || ut_warn_hit)
    |=> (ot_warn_flag_out || ut_warn_flag_out) && power_en_out == $past(power_en_r, 1)
    || $past(ot_fault) || !$past(cmd_on))
    else $error("warning flag not raised");
endmodule : otr_fault_resp

// >>> rtl/otr_lin_decode.sv
// Purpose: Linear-format word to signed fixed point
// Assumes: Exponent in bits 15:11, mantissa in bits 10:0, both two's complement
// Notes:   Purely combinational; exact for every code
`timescale 1ns/1ps
module otr_lin_decode
  import otr_pkg::*;
(
  input  wire logic [15:0]             lin_in,
  output logic signed [FIX_W-1:0]      fix_out
);
  logic [4:0] shamt;

  // Flipping the sign bit adds the bias of 16, giving a shift of 0..31
  assign shamt   = lin_in[15:11] ^ EXP_BIAS_FLIP;
  assign fix_out = {{(FIX_W-MANT_W){lin_in[MANT_W-1]}}, lin_in[MANT_W-1:0]} << shamt;
endmodule : otr_lin_decode

// >>> verif/otr_fault_resp_bench.sv
// Purpose: Self-checking bench for the over-temperature fault reaction
// Assumes: Temperatures use exponent 0, so the mantissa is whole degrees
// Notes:   Delay timing is judged by differences, so fixed pipeline latency cancels
`timescale 1ns/1ps
module otr_fault_resp_bench;
  import otr_pkg::*;
  localparam logic [15:0] HOT  = 16'h0096;
  localparam logic [15:0] NORM = 16'h0032;
  logic        ref_clk_in, rst_n_in, cmd_valid_in, cmd_write_in, cmd_ack_out, cmd_nak_out;
  logic [7:0]  cmd_code_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, temp_in, delay_unit_in;
  logic        clear_faults_in, ot_flag_clr_in, ctrl_pin_on_in, operation_on_in;
  logic        other_fault_in, power_en_out, retry_attempt_out;
  logic        ot_fault_flag_out, ot_warn_flag_out, ut_warn_flag_out;
  int          failures, checked, cyc, attempts, first_at, t0, tu;
  int          tm [8];

  otr_fault_resp dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
    .cmd_ack_out(cmd_ack_out), .cmd_nak_out(cmd_nak_out), .cmd_rdata_out(cmd_rdata_out),
    .clear_faults_in(clear_faults_in), .ot_flag_clr_in(ot_flag_clr_in),
    .ctrl_pin_on_in(ctrl_pin_on_in), .operation_on_in(operation_on_in),
    .other_fault_in(other_fault_in), .temp_in(temp_in), .delay_unit_in(delay_unit_in),
    .power_en_out(power_en_out), .retry_attempt_out(retry_attempt_out),
    .ot_fault_flag_out(ot_fault_flag_out), .ot_warn_flag_out(ot_warn_flag_out),
    .ut_warn_flag_out(ut_warn_flag_out)
  );

  otr_host_model host (
    .ref_clk_in(ref_clk_in), .ack_in(cmd_ack_out), .nak_in(cmd_nak_out),
    .rdata_in(cmd_rdata_out), .valid_out(cmd_valid_in), .write_out(cmd_write_in),
    .code_out(cmd_code_in), .wdata_out(cmd_wdata_in)
  );

  always #2 ref_clk_in = ~ref_clk_in;

  // Attempt monitor and hang guard
  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (retry_attempt_out === 1'b1)
    begin
      if (attempts == 0)
        first_at = cyc;
      attempts = attempts + 1;
    end
    if (cyc > 20000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : wt

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic a, n;
    logic [15:0] d;
    host.xfer(1'b1, code, data, a, n, d);
    chk(16'({a, n}), 16'h0002);
  endtask : wr

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic a, n;
    logic [15:0] d;
    host.xfer(1'b0, code, 16'h0000, a, n, d);
    chk(16'({a, n}), (code >= CMD_OT_FLT_LIM && code <= CMD_UT_WARN) ? 16'h0002 : 16'h0001);
    chk(d, exp);
  endtask : rd

  // Program a reaction, then overheat; t0 marks the first hot cycle
  task automatic heat(input logic [7:0] react, input logic [15:0] unit);
    delay_unit_in = unit;
    wr(CMD_OT_REACT, {8'h00, react});
    attempts = 0;
    temp_in  = HOT;
    t0       = cyc;
  endtask : heat

  task automatic cool();
    temp_in         = NORM;
    clear_faults_in = 1'b1;
    wt(1);
    clear_faults_in = 1'b0;
    wt(3);
    chk(16'(power_en_out), 16'h0001);
  endtask : cool

  initial
  begin
    {ref_clk_in, rst_n_in, clear_faults_in, ot_flag_clr_in, other_fault_in} = '0;
    {failures, checked, cyc, attempts, first_at, t0} = '0;
    ctrl_pin_on_in  = 1'b1;
    operation_on_in = 1'b1;
    temp_in         = NORM;
    delay_unit_in   = 16'h0002;
    wt(2);
    rst_n_in = 1'b1;
    rd(CMD_OT_REACT, {8'h00, REACT_RST});
    rd(CMD_OT_FLT_LIM, OT_FLT_RST);
    rd(CMD_OT_WARN, OT_WARN_RST);
    rd(CMD_UT_WARN, UT_WARN_RST);
    rd(8'h53, 16'h0000);
    wr(CMD_OT_FLT_LIM, 16'h0078);
    rd(CMD_OT_FLT_LIM, 16'h0078);
    wr(CMD_OT_WARN, 16'h0064);
    rd(CMD_OT_WARN, 16'h0064);
    wr(CMD_UT_WARN, 16'h07ec);
    rd(CMD_UT_WARN, 16'h07ec);
    // Warnings: 110 above 100, then -50 below -20, output untouched
    temp_in = 16'h006e;
    wt(3);
    chk(16'({ot_warn_flag_out, ut_warn_flag_out, ot_fault_flag_out}), 16'h0004);
    temp_in = 16'h07ce;
    wt(3);
    chk(16'({ut_warn_flag_out, power_en_out}), 16'h0003);
    cool();
    chk(16'({ot_warn_flag_out, ut_warn_flag_out}), 16'h0000);
    heat(8'h00, 16'h0002);
    wt(40);
    chk(16'({power_en_out, ot_fault_flag_out}), 16'h0003);
    chk(16'(attempts), 16'h0000);
    cool();
    // Latch-off, cleared four ways
    for (int k = 0; k < 4; k++)
    begin
      heat(8'hc0, 16'h0002);
      wt(3);
      chk(16'({power_en_out, ot_fault_flag_out}), 16'h0001);
      temp_in = NORM;
      wt(20);
      chk(16'(power_en_out), 16'h0000);
      ot_flag_clr_in  = (k == 0);
      clear_faults_in = (k == 1);
      ctrl_pin_on_in  = (k != 2);
      operation_on_in = (k != 3);
      wt(2);
      {ot_flag_clr_in, clear_faults_in, ctrl_pin_on_in, operation_on_in} = 4'h3;
      wt(3);
      chk(16'(power_en_out), 16'h0001);
    end
    // Retry counts 0..6 with the fault held throughout
    for (int n = 0; n < 7; n++)
    begin
      heat({2'b10, n[2:0], 3'h0}, 16'h0002);
      wt(3);
      chk(16'(power_en_out), 16'h0000);
      wt((n + 2) * 12);
      chk(16'(attempts), 16'(n));
      chk(16'(power_en_out), 16'h0000);
      cool();
    end
    // Delay decode: time to first attempt grows with 2^code units
    for (int d = 0; d < 8; d++)
    begin
      heat({5'b10001, d[2:0]}, 16'h0002);
      wt(2 * (1 << d) + 20);
      tm[d] = first_at - t0;
      cool();
    end
    for (int d = 1; d < 8; d++)
      chk(16'(tm[d] - tm[0]), 16'(2 * (1 << d) - 2));
    heat(8'h88, 16'h0004);
    wt(30);
    tu = first_at - t0;
    cool();
    chk(16'(tu - tm[0]), 16'h0002);
    // Run-on for 16 cycles, then disable
    heat(8'h4b, 16'h0002);
    wt(12);
    chk(16'(power_en_out), 16'h0001);
    wt(10);
    chk(16'(power_en_out), 16'h0000);
    // The single attempt must end before a clear can bring the output back
    wt(20);
    chk(16'({attempts[14:0], power_en_out}), 16'h0002);
    cool();
    heat(8'h4b, 16'h0002);
    wt(5);
    temp_in = NORM;
    wt(30);
    chk(16'(power_en_out), 16'h0001);
    cool();
    // Endless retry, stopped by the pin, then by another fault
    heat(8'hb8, 16'h0002);
    wt(100);
    chk(16'(attempts > 8), 16'h0001);
    ctrl_pin_on_in = 1'b0;
    wt(3);
    attempts = 0;
    wt(40);
    chk(16'({attempts[14:0], power_en_out}), 16'h0000);
    ctrl_pin_on_in = 1'b1;
    cool();
    heat(8'hb8, 16'h0002);
    wt(30);
    other_fault_in = 1'b1;
    wt(3);
    attempts = 0;
    wt(40);
    chk(16'(attempts), 16'h0000);
    chk(16'(power_en_out), 16'h0000);
    other_fault_in = 1'b0;
    cool();
    // Reset in mid-run clears a latched fault and restores the fault limit and reaction
    heat(8'hc0, 16'h0002);
    wt(3);
    chk(16'({power_en_out, ot_fault_flag_out}), 16'h0001);
    rst_n_in = 1'b0;
    temp_in  = NORM;
    wt(2);
    rst_n_in = 1'b1;
    wt(2);
    chk(16'({power_en_out, ot_fault_flag_out}), 16'h0002);
    rd(CMD_OT_FLT_LIM, OT_FLT_RST);
    rd(CMD_OT_REACT, {8'h00, REACT_RST});
    finish_test();
  end
endmodule : otr_fault_resp_bench

// >>> verif/otr_host_model.sv
// Purpose: Management host model that issues command reads and writes
// Assumes: Answer shows the cycle after the edge that takes the request
// Notes:   Idle command lines carry inverted values so stale data never looks valid
`timescale 1ns/1ps
module otr_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        ack_in,
  input  wire logic        nak_in,
  input  wire logic [15:0] rdata_in,
  output logic             valid_out,
  output logic             write_out,
  output logic [7:0]       code_out,
  output logic [15:0]      wdata_out
);
  initial
  begin
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out  = 8'hff;
    wdata_out = 16'hffff;
  end

  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
                      output logic ack, output logic nak, output logic [15:0] rd);
    @(negedge ref_clk_in);
    valid_out = 1'b1;
    write_out = w;
    code_out  = code;
    wdata_out = data;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    ack       = ack_in;
    nak       = nak_in;
    rd        = rdata_in;
    valid_out = 1'b0;
    code_out  = ~code;
    wdata_out = ~data;
  endtask : xfer
endmodule : otr_host_model
